// [src/lct_pkg.sv]
// Purpose: shared constants for the command timing controller
// Assumes: controller clock of 125 MHz (8 ns period)
// Notes:   times in picoseconds, counts derived by rounding up
package lct_pkg;
    // ========================================================
    // clock
    localparam int CLK_PERIOD_PS = 8000;
    // ========================================================
    // command codes
    typedef enum logic [3:0] {
        LCT_CMD_NOP   = 4'h0,
        LCT_CMD_MRW   = 4'h1,
        LCT_CMD_MRR   = 4'h2,
        LCT_CMD_ACT   = 4'h3,
        LCT_CMD_RD    = 4'h4,
        LCT_CMD_WR    = 4'h5,
        LCT_CMD_PRE   = 4'h6,
        LCT_CMD_PREA  = 4'h7,
        LCT_CMD_SREN  = 4'h8,
        LCT_CMD_SREX  = 4'h9,
        LCT_CMD_PDEN  = 4'ha,
        LCT_CMD_PDEX  = 4'hb,
        LCT_CMD_DPEN  = 4'hc,
        LCT_CMD_DPEX  = 4'hd
    } lct_cmd_t;
    // ========================================================
    // times in ps (mode spacing in clocks, deep sleep in us)
    localparam int MODE_WRITE_SPACING_CK        = 5;
    localparam int MODE_READ_SPACING_CK         = 2;
    localparam int SELF_REFRESH_MIN_LOW_PS      = 15000;
    localparam int SELF_REFRESH_MIN_LOW_FLOOR   = 3;
    localparam int SELF_REFRESH_EXIT_ADD_PS     = 10000;
    localparam int SELF_REFRESH_EXIT_FLOOR      = 2;
    localparam int POWERDOWN_EXIT_DELAY_PS      = 7500;
    localparam int POWERDOWN_EXIT_FLOOR         = 2;
    localparam int READ_TO_PRECHARGE_DELAY_PS   = 7500;
    localparam int READ_TO_PRECHARGE_FLOOR      = 2;
    localparam int SINGLE_BANK_PRECHARGE_PS     = 18000;
    localparam int SINGLE_BANK_PRECHARGE_FLOOR  = 3;
    localparam int WRITE_TO_READ_DELAY_PS       = 7500;
    localparam int WRITE_TO_READ_FLOOR          = 2;
    localparam int ACTIVATE_TO_ACTIVATE_PS      = 10000;
    localparam int ACTIVATE_TO_ACTIVATE_FLOOR   = 2;
    localparam int FOUR_ACTIVATE_WINDOW_PS      = 50000;
    localparam int FOUR_ACTIVATE_WINDOW_SLOW_PS = 60000;
    localparam int FOUR_ACTIVATE_WINDOW_FLOOR   = 8;
    localparam int DEEP_SLEEP_MIN_TIME_US       = 500;
    localparam int FLOOR_APPLIES_ABOVE_PS       = 6000;
    localparam int BOOT_CLOCK_PERIOD_MIN_PS     = 18000;
    localparam int BOOT_CLOCK_PERIOD_MAX_PS     = 100000;
    // latency tables, fastest grade first (index 0..6)
    localparam logic [27:0] READ_LATENCY_TABLE  = {4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
    localparam logic [27:0] WRITE_LATENCY_TABLE = {4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4};
    // ========================================================
    // conversion: round up, then floor only above 6 ns clock
    function automatic int lct_cycles(input int t_ps, input int floor_ck, input int per_ps);
        int c;
        c = (t_ps + per_ps - 1) / per_ps;
        if (per_ps > FLOOR_APPLIES_ABOVE_PS && c < floor_ck) begin
            c = floor_ck;
        end
        if (c < 1) begin
            c = 1;
        end
        return c;
    endfunction
    localparam int BOOT_DIV_CYCLES = (BOOT_CLOCK_PERIOD_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 24;
endpackage

// [src/lct_down_counter.sv]
// Purpose: reloadable down counter signalling expiry
// Assumes: load wins over counting
// Notes:   o_zero high when the interval has elapsed
`timescale 1ns/1ps
module lct_down_counter
    import lct_pkg::*;
#(
    parameter int W = CNT_W
) (
    // clock and reset
    input  wire logic         i_clock,
    input  wire logic         i_nrst,
    // control
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    // status
    output logic              o_zero
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } lct_dc_t;
    lct_dc_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        if (i_load) begin
            st_d.cnt = i_value;
        end else if (st_q.cnt != '0) begin
            st_d.cnt = st_q.cnt - W'(1);
        end
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign o_zero = (st_q.cnt == '0);
endmodule

// [src/lct_latency_pipe.sv]
// Purpose: delays a command marker by a grade-selected latency
// Assumes: latency 1..15 cycles
// Notes:   shift line of flip-flops, tap picked by index
`timescale 1ns/1ps
module lct_latency_pipe
    import lct_pkg::*;
#(
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    // marker
    input  wire logic       i_mark,
    input  wire logic [3:0] i_lat,
    output logic            o_mark
);
    typedef struct packed {
        logic [DEPTH-1:0] sr;
        logic             out;
    } lct_lp_t;
    lct_lp_t st_q, st_d;
    always_comb begin
        st_d = st_q;
        st_d.sr = {st_q.sr[DEPTH-2:0], i_mark};
        // registered tap lat-1: high lat cycles after issue
        st_d.out = (i_lat == 4'h0) ? 1'b0 : st_q.sr[i_lat - 4'h1];
    end
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign o_mark = st_q.out;
endmodule

// [src/lct_controller.sv]
// Purpose: host-side command scheduler enforcing memory timing
// Assumes: at most one command every two cycles on a request/grant port
// Notes:   commands held until all spacing timers allow them
`timescale 1ns/1ps
module lct_controller
    import lct_pkg::*;
#(
    parameter int            BANKS          = 8,
    parameter int            BANK_W         = 3,
    parameter int            ROW_ACTIVE_PS  = 42000,
    parameter int            ALL_PRE_PS     = 21000,
    parameter int            REFRESH_AB_PS  = 130000,
    parameter int            DEEP_SLEEP_CYC = 62500,
    parameter int            WRITE_END_CYC  = 4
) (
    // clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_nrst,
    // request port
    input  wire logic              i_req_valid,
    input  wire lct_cmd_t          i_req_cmd,
    input  wire logic [BANK_W-1:0] i_req_bank,
    output logic                   o_req_ready,
    // configuration
    input  wire logic              i_configured,
    input  wire logic [2:0]        i_grade,
    // memory command side
    output logic                   o_cmd_valid,
    output lct_cmd_t               o_cmd,
    output logic [BANK_W-1:0]      o_cmd_bank,
    output logic                   o_cke,
    output logic                   o_boot_clk,
    // data timing markers
    output logic                   o_rd_data_due,
    output logic                   o_wr_data_due
);
    // ========================================================
    // derived counts
    localparam int PER = CLK_PERIOD_PS;
    localparam int C_XP   = lct_cycles(POWERDOWN_EXIT_DELAY_PS, POWERDOWN_EXIT_FLOOR, PER);
    localparam int C_RTP  = lct_cycles(READ_TO_PRECHARGE_DELAY_PS, READ_TO_PRECHARGE_FLOOR, PER);
    localparam int C_RP   = lct_cycles(SINGLE_BANK_PRECHARGE_PS, SINGLE_BANK_PRECHARGE_FLOOR, PER);
    localparam int C_RPA  = lct_cycles(ALL_PRE_PS, SINGLE_BANK_PRECHARGE_FLOOR, PER);
    localparam int C_WTR  = lct_cycles(WRITE_TO_READ_DELAY_PS, WRITE_TO_READ_FLOOR, PER);
    localparam int C_RRD  = lct_cycles(ACTIVATE_TO_ACTIVATE_PS, ACTIVATE_TO_ACTIVATE_FLOOR, PER);
    localparam int C_SRL  = lct_cycles(SELF_REFRESH_MIN_LOW_PS, SELF_REFRESH_MIN_LOW_FLOOR, PER);
    localparam int C_XSR  = lct_cycles(REFRESH_AB_PS + SELF_REFRESH_EXIT_ADD_PS,
                                       SELF_REFRESH_EXIT_FLOOR, PER);
    localparam int C_RC   = lct_cycles(ROW_ACTIVE_PS + SINGLE_BANK_PRECHARGE_PS, 1, PER);
    localparam int C_FAW  = lct_cycles(FOUR_ACTIVATE_WINDOW_PS, FOUR_ACTIVATE_WINDOW_FLOOR, PER);
    localparam int C_FAWS = lct_cycles(FOUR_ACTIVATE_WINDOW_SLOW_PS,
                                       FOUR_ACTIVATE_WINDOW_FLOOR, PER);
    // boot timings at the slow clock period
    localparam int BP = BOOT_DIV_CYCLES * PER;
    localparam int B_SCALE = BOOT_DIV_CYCLES;
    localparam int B_XP  = lct_cycles(POWERDOWN_EXIT_DELAY_PS, POWERDOWN_EXIT_FLOOR, BP) * B_SCALE;
    localparam int B_RP  = lct_cycles(SINGLE_BANK_PRECHARGE_PS, SINGLE_BANK_PRECHARGE_FLOOR, BP)
                           * B_SCALE;
    localparam int B_MRW = MODE_WRITE_SPACING_CK * B_SCALE;
    localparam int B_MRR = MODE_READ_SPACING_CK * B_SCALE;
    localparam int B_GEN = lct_cycles(ACTIVATE_TO_ACTIVATE_PS, ACTIVATE_TO_ACTIVATE_FLOOR, BP)
                           * B_SCALE;

    typedef enum logic [3:0] {
        PS_ACTIVE = 4'h1,
        PS_SREF   = 4'h2,
        PS_PDOWN  = 4'h4,
        PS_DEEP   = 4'h8
    } lct_pwr_t;

    typedef struct packed {
        lct_pwr_t          pwr;
        logic              cmd_valid;
        lct_cmd_t          cmd;
        logic [BANK_W-1:0] bank;
        logic              cke;
        logic              boot_clk;
        logic [7:0]        div;
        logic [3:0]        faw_ptr;
    } lct_st_t;
    lct_st_t st_q, st_d;

    // ========================================================
    // timers
    logic [CNT_W-1:0] gen_val, rrd_val, rtp_val, wtr_val, srl_val;
    logic             gen_ld, rrd_ld, rtp_ld, wtr_ld, srl_ld;
    logic             gen_ok, rrd_ok, rtp_ok, wtr_ok, srl_ok;
    logic [BANKS-1:0] rc_ld, rp_ld, rc_ok, rp_ok, faw_ld, faw_ok;
    logic [CNT_W-1:0] rp_val;
    logic             take;
    logic             boot;
    logic             allow;
    logic             rd_mark, wr_mark, wr_end;

    lct_down_counter u_gen (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(gen_ld),
                            .i_value(gen_val), .o_zero(gen_ok));
    lct_down_counter u_rrd (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(rrd_ld),
                            .i_value(rrd_val), .o_zero(rrd_ok));
    lct_down_counter u_rtp (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(rtp_ld),
                            .i_value(rtp_val), .o_zero(rtp_ok));
    lct_down_counter u_wtr (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(wtr_ld),
                            .i_value(wtr_val), .o_zero(wtr_ok));
    lct_down_counter u_srl (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(srl_ld),
                            .i_value(srl_val), .o_zero(srl_ok));

    genvar g;
    generate
        for (g = 0; g < BANKS; g++) begin : g_bank
            lct_down_counter u_rc (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(rc_ld[g]),
                                   .i_value(CNT_W'(C_RC)), .o_zero(rc_ok[g]));
            lct_down_counter u_rp (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(rp_ld[g]),
                                   .i_value(rp_val), .o_zero(rp_ok[g]));
            // only four slots serve the window
            lct_down_counter u_faw (.i_clock(i_clock), .i_nrst(i_nrst), .i_load(faw_ld[g]),
                                    .i_value((i_grade == 3'h6) ? CNT_W'(C_FAWS) : CNT_W'(C_FAW)),
                                    .o_zero(faw_ok[g]));
        end
    endgenerate

    // ========================================================
    // latency markers
    lct_latency_pipe u_rd_lat (.i_clock(i_clock), .i_nrst(i_nrst), .i_mark(rd_mark),
                           .i_lat(READ_LATENCY_TABLE[i_grade*4 +: 4]), .o_mark(o_rd_data_due));
    lct_latency_pipe u_wr_lat (.i_clock(i_clock), .i_nrst(i_nrst), .i_mark(wr_mark),
                           .i_lat(WRITE_LATENCY_TABLE[i_grade*4 +: 4]), .o_mark(o_wr_data_due));

    assign boot = !i_configured;

    // ========================================================
    // admission check
    always_comb begin
        allow = gen_ok;
        unique case (i_req_cmd)
            LCT_CMD_ACT: allow = gen_ok && rrd_ok && rc_ok[i_req_bank] && rp_ok[i_req_bank]
                                 && faw_ok[st_q.faw_ptr[1:0]];
            LCT_CMD_PRE, LCT_CMD_PREA: allow = gen_ok && rtp_ok;
            LCT_CMD_RD: allow = gen_ok && wtr_ok;
            LCT_CMD_SREX: allow = gen_ok && srl_ok;
            LCT_CMD_DPEX: allow = gen_ok && srl_ok;
            default: allow = gen_ok;
        endcase
        // boot: issue on slow clock phase 0 only
        if (boot && st_q.div != 8'h0) begin
            allow = 1'b0;
        end
    end
    assign take = i_req_valid && allow && st_q.cmd_valid == 1'b0;
    assign rd_mark = take && i_req_cmd == LCT_CMD_RD;
    assign wr_mark = take && i_req_cmd == LCT_CMD_WR;
    assign wr_end  = wr_mark;

    always_comb begin
        gen_ld = take;
        gen_val = CNT_W'(1);
        unique case (i_req_cmd)
            LCT_CMD_MRW:  gen_val = boot ? CNT_W'(B_MRW) : CNT_W'(MODE_WRITE_SPACING_CK);
            LCT_CMD_MRR:  gen_val = boot ? CNT_W'(B_MRR) : CNT_W'(MODE_READ_SPACING_CK);
            LCT_CMD_SREX: gen_val = CNT_W'(C_XSR);
            LCT_CMD_PDEX: gen_val = boot ? CNT_W'(B_XP) : CNT_W'(C_XP);
            default:      gen_val = boot ? CNT_W'(B_GEN) : CNT_W'(1);
        endcase
        rrd_ld  = take && i_req_cmd == LCT_CMD_ACT;
        rrd_val = CNT_W'(C_RRD);
        rtp_ld  = rd_mark;
        rtp_val = CNT_W'(C_RTP);
        wtr_ld  = wr_end;
        wtr_val = CNT_W'(C_WTR + WRITE_END_CYC);
        srl_ld  = take && (i_req_cmd == LCT_CMD_SREN || i_req_cmd == LCT_CMD_DPEN);
        srl_val = (i_req_cmd == LCT_CMD_DPEN) ? CNT_W'(DEEP_SLEEP_CYC) : CNT_W'(C_SRL);
        rp_val  = boot ? CNT_W'(B_RP)
                       : ((i_req_cmd == LCT_CMD_PREA) ? CNT_W'(C_RPA) : CNT_W'(C_RP));
        rc_ld   = '0;
        rp_ld   = '0;
        faw_ld  = '0;
        if (take && i_req_cmd == LCT_CMD_ACT) begin
            rc_ld[i_req_bank] = 1'b1;
            faw_ld[st_q.faw_ptr[1:0]] = 1'b1;
        end
        if (take && i_req_cmd == LCT_CMD_PRE) begin
            rp_ld[i_req_bank] = 1'b1;
        end
        if (take && i_req_cmd == LCT_CMD_PREA) begin
            rp_ld = '1;
        end
    end

    // ========================================================
    // state update
    always_comb begin
        st_d = st_q;
        st_d.cmd_valid = take;
        st_d.cmd = take ? i_req_cmd : LCT_CMD_NOP;
        st_d.bank = take ? i_req_bank : st_q.bank;
        // boot clock divided down to the slow range
        if (st_q.div >= 8'(BOOT_DIV_CYCLES - 1)) begin
            st_d.div = 8'h0;
        end else begin
            st_d.div = st_q.div + 8'h1;
        end
        st_d.boot_clk = boot ? (st_d.div < 8'(BOOT_DIV_CYCLES / 2)) : 1'b0;
        if (take && i_req_cmd == LCT_CMD_ACT) begin
            st_d.faw_ptr = st_q.faw_ptr + 4'h1;
        end
        unique case (st_q.pwr)
            PS_ACTIVE: begin
                if (take && i_req_cmd == LCT_CMD_SREN) begin
                    st_d.pwr = PS_SREF;
                end else if (take && i_req_cmd == LCT_CMD_PDEN) begin
                    st_d.pwr = PS_PDOWN;
                end else if (take && i_req_cmd == LCT_CMD_DPEN) begin
                    st_d.pwr = PS_DEEP;
                end
            end
            PS_SREF: if (take && i_req_cmd == LCT_CMD_SREX) st_d.pwr = PS_ACTIVE;
            PS_PDOWN: if (take && i_req_cmd == LCT_CMD_PDEX) st_d.pwr = PS_ACTIVE;
            PS_DEEP: if (take && i_req_cmd == LCT_CMD_DPEX) st_d.pwr = PS_ACTIVE;
            default: st_d.pwr = PS_ACTIVE;
        endcase
        st_d.cke = (st_d.pwr == PS_ACTIVE);
    end

    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= '{pwr: PS_ACTIVE, cmd: LCT_CMD_NOP, default: '0};
        end else begin
            st_q <= st_d;
        end
    end

    assign o_req_ready = st_q.cmd_valid == 1'b0 && allow;
    assign o_cmd_valid = st_q.cmd_valid;
    assign o_cmd       = st_q.cmd;
    assign o_cmd_bank  = st_q.bank;
    assign o_cke       = st_q.cke;
    assign o_boot_clk  = st_q.boot_clk;
endmodule

// [bench/lct_monitor.sv]
// Purpose: concurrent checks on the command scheduler outputs
// Assumes: 8 ns clock, grade held while data is due
// Notes:   gap_q counts cycles since the previous command
`timescale 1ns/1ps
module lct_monitor
    import lct_pkg::*;
#(
    parameter int BANK_W         = 3,
    parameter int REFRESH_AB_PS  = 130000,
    parameter int DEEP_SLEEP_CYC = 62500
) (
    // clock and reset
    input wire logic              i_clock,
    input wire logic              i_nrst,
    // configuration
    input wire logic              i_configured,
    input wire logic [2:0]        i_grade,
    // command side
    input wire logic              o_cmd_valid,
    input wire lct_cmd_t          o_cmd,
    input wire logic [BANK_W-1:0] o_cmd_bank,
    input wire logic              o_boot_clk,
    input wire logic              o_rd_data_due,
    input wire logic              o_wr_data_due
);
    // rounded up at 8 ns, refresh plus 10 ns
    localparam int XSR_CK = (REFRESH_AB_PS + 10000 + 7999) / 8000;
    logic [15:0] gap_q;
    lct_cmd_t    last_q;
    logic [15:0] rd_q;
    logic [15:0] wr_q;
    logic [6:0]  act_q;
    logic        act;
    assign act = o_cmd_valid && (o_cmd == LCT_CMD_ACT);
    // ==========================================================
    // history
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            gap_q  <= 16'hffff;
            last_q <= LCT_CMD_NOP;
            rd_q   <= '0;
            wr_q   <= '0;
            act_q  <= '0;
        end else begin
            gap_q  <= o_cmd_valid ? 16'h0001 : gap_q + {15'h0000, gap_q != 16'hffff};
            last_q <= o_cmd_valid ? o_cmd : last_q;
            rd_q   <= {rd_q[14:0], o_cmd_valid && (o_cmd == LCT_CMD_RD)};
            wr_q   <= {wr_q[14:0], o_cmd_valid && (o_cmd == LCT_CMD_WR)};
            act_q  <= {act_q[5:0], act};
        end
    end
    // ==========================================================
    // assertions
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    mrw_spacing_a: assert property (o_cmd_valid && last_q == LCT_CMD_MRW |-> gap_q >= 5)
        else $error("mode write gap short");
    sr_low_a: assert property (o_cmd_valid && last_q == LCT_CMD_SREN |-> gap_q >= 3)
        else $error("self refresh too short");
    sr_exit_a: assert property (o_cmd_valid && last_q == LCT_CMD_SREX |-> gap_q >= XSR_CK)
        else $error("self refresh exit gap short");
    pd_exit_a: assert property (o_cmd_valid && last_q == LCT_CMD_PDEX |-> gap_q >= 2)
        else $error("power down exit gap short");
    dp_hold_a: assert property (o_cmd_valid && last_q == LCT_CMD_DPEN |-> gap_q >= DEEP_SLEEP_CYC)
        else $error("deep sleep too short");
    rd_latency_a: assert property (o_rd_data_due == rd_q[READ_LATENCY_TABLE[4*i_grade +: 4] - 4'h1])
        else $error("read latency off");
    wr_latency_a: assert property (o_wr_data_due == wr_q[WRITE_LATENCY_TABLE[4*i_grade +: 4] - 4'h1])
        else $error("write latency off");
    act_reopen_a: assert property (o_cmd_valid && o_cmd == LCT_CMD_PRE |=>
        !(act && o_cmd_bank == $past(o_cmd_bank)) ##1 !(act && o_cmd_bank == $past(o_cmd_bank, 2)))
        else $error("reopen after precharge early");
    act_spread_a: assert property (act |=> !act)
        else $error("activates too close");
    four_act_a: assert property ($countones({act_q, act}) <= 4)
        else $error("over four activates");
    boot_rate_a: assert property (!i_configured && $rose(o_boot_clk) |=>
        !$rose(o_boot_clk) ##1 !$rose(o_boot_clk))
        else $error("boot clock too fast");
    boot_off_a: assert property ($past(i_configured) && i_configured |-> !o_boot_clk)
        else $error("boot clock after config");
endmodule
bind lct_controller lct_monitor #(
    .BANK_W        (BANK_W),
    .REFRESH_AB_PS (REFRESH_AB_PS),
    .DEEP_SLEEP_CYC(DEEP_SLEEP_CYC)
) u_mon (
    .i_clock      (i_clock),
    .i_nrst       (i_nrst),
    .i_configured (i_configured),
    .i_grade      (i_grade),
    .o_cmd_valid  (o_cmd_valid),
    .o_cmd        (o_cmd),
    .o_cmd_bank   (o_cmd_bank),
    .o_boot_clk   (o_boot_clk),
    .o_rd_data_due(o_rd_data_due),
    .o_wr_data_due(o_wr_data_due)
);

// [bench/lct_dev_model.sv]
// Purpose: behavioural memory device on the command side
// Assumes: grade fixed while a data beat is due
// Notes:   beats are markers only, no data is stored
`timescale 1ns/1ps
module lct_dev_model
    import lct_pkg::*;
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_nrst,
    // command side
    input  wire logic       i_cmd_valid,
    input  wire lct_cmd_t   i_cmd,
    input  wire logic       i_cke,
    input  wire logic [2:0] i_grade,
    // observation
    output logic            o_rd_beat,
    output logic            o_wr_beat,
    output int              o_viol
);
    logic [15:0] rd_q;
    logic [15:0] wr_q;
    logic [7:0]  mode_q;
    assign o_rd_beat = rd_q[READ_LATENCY_TABLE[4*i_grade +: 4] - 4'h1];
    assign o_wr_beat = wr_q[WRITE_LATENCY_TABLE[4*i_grade +: 4] - 4'h1];
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            rd_q   <= '0;
            wr_q   <= '0;
            mode_q <= 8'h00;
            o_viol <= 0;
        end else begin
            rd_q <= {rd_q[14:0], i_cmd_valid && i_cmd == LCT_CMD_RD};
            wr_q <= {wr_q[14:0], i_cmd_valid && i_cmd == LCT_CMD_WR};
            // no address on this port, so every mode write reloads defaults
            if (i_cmd_valid && i_cmd == LCT_CMD_MRW) begin
                mode_q <= 8'h00;
            end
            // only entry and exit commands may ride on a low clock enable
            if (i_cmd_valid && !i_cke && !(i_cmd inside {LCT_CMD_SREN, LCT_CMD_SREX,
                LCT_CMD_PDEN, LCT_CMD_PDEX, LCT_CMD_DPEN, LCT_CMD_DPEX})) begin
                o_viol <= o_viol + 1;
            end
        end
    end
endmodule

// [bench/tb.sv]
// Purpose: self-checking bench for the command timing controller
// Assumes: 125 MHz clock, deep sleep shortened to DSC cycles
// Notes:   cyc counts falling edges
`timescale 1ns/1ps
module tb
    import lct_pkg::*;
;
    localparam int DSC = 50;
    logic       i_clock;
    logic       i_nrst;
    logic       i_req_valid;
    lct_cmd_t   i_req_cmd;
    logic [2:0] i_req_bank;
    logic       i_configured;
    logic [2:0] i_grade;
    logic       o_req_ready;
    logic       o_cmd_valid;
    lct_cmd_t   o_cmd;
    logic [2:0] o_cmd_bank;
    logic       o_cke;
    logic       o_boot_clk;
    logic       o_rd_data_due;
    logic       o_wr_data_due;
    logic       dev_rd;
    logic       dev_wr;
    int         dev_viol;
    int         num_errors;
    int         n_checks;
    int         cyc;
    int         last_take;
    int         gap;
    // ==========================================================
    // design and device
    lct_controller #(.DEEP_SLEEP_CYC(DSC)) u_lct_controller (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_req_valid(i_req_valid), .i_req_cmd(i_req_cmd),
        .i_req_bank(i_req_bank), .o_req_ready(o_req_ready), .i_configured(i_configured),
        .i_grade(i_grade), .o_cmd_valid(o_cmd_valid), .o_cmd(o_cmd), .o_cmd_bank(o_cmd_bank),
        .o_cke(o_cke), .o_boot_clk(o_boot_clk), .o_rd_data_due(o_rd_data_due),
        .o_wr_data_due(o_wr_data_due));
    lct_dev_model u_lct_dev_model (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_cmd_valid(o_cmd_valid), .i_cmd(o_cmd),
        .i_cke(o_cke), .i_grade(i_grade), .o_rd_beat(dev_rd), .o_wr_beat(dev_wr),
        .o_viol(dev_viol));
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    always @(negedge i_clock) cyc <= cyc + 1;
    // ==========================================================
    // helpers
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            num_errors++;
        end
    endtask
    task automatic bound(input int n);
        if (n > 300) begin
            num_errors++;
            test_done();
        end
    endtask
    // held from a falling edge until ready at a rising edge
    task automatic issue(input lct_cmd_t c, input logic [2:0] b);
        int n = 0;
        @(negedge i_clock);
        i_req_valid = 1'b1;
        i_req_cmd = c;
        i_req_bank = b;
        #1;
        while (o_req_ready !== 1'b1) begin
            n++;
            bound(n);
            @(negedge i_clock);
            #1;
        end
        @(posedge i_clock);
        gap = cyc - last_take;
        last_take = cyc;
        @(negedge i_clock);
        i_req_valid = 1'b0;
        i_req_cmd = LCT_CMD_NOP;
        check(o_cmd_valid, 1);
        check(o_cmd, c);
        check(o_cmd_bank, b);
    endtask
    task automatic boot_rise(output int t);
        int n = 0;
        logic prev;
        prev = o_boot_clk;
        @(negedge i_clock);
        while (!(prev === 1'b0 && o_boot_clk === 1'b1)) begin
            prev = o_boot_clk;
            n++;
            bound(n * 8);
            @(negedge i_clock);
        end
        t = cyc;
    endtask
    task automatic watch(input int lat, input bit is_rd);
        int pos = 0;
        int cnt = 0;
        logic due;
        for (int k = 1; k <= 12; k++) begin
            @(negedge i_clock);
            due = is_rd ? o_rd_data_due : o_wr_data_due;
            check(due, is_rd ? dev_rd : dev_wr);
            if (due === 1'b1) begin
                cnt++;
                pos = k;
            end
        end
        check(cnt, 1);
        check(pos, lat);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_boot();
        int t1;
        int t2;
        boot_rise(t1);
        boot_rise(t2);
        check((t2 - t1) * 8 >= 18 && (t2 - t1) * 8 <= 100, 1);
        issue(LCT_CMD_MRW, 3'h0);
        issue(LCT_CMD_MRW, 3'h0);
        check(gap >= 15, 1);
        i_configured = 1'b1;
        repeat (3) begin
            @(negedge i_clock);
            check(o_boot_clk, 0);
        end
    endtask
    task automatic t_mode();
        issue(LCT_CMD_MRW, 3'h0);
        issue(LCT_CMD_MRR, 3'h0);
        check(gap >= 5, 1);
        issue(LCT_CMD_MRW, 3'h0);
        check(gap >= 2, 1);
    endtask
    task automatic t_bank();
        int acts[$];
        issue(LCT_CMD_ACT, 3'h0);
        acts.push_back(last_take);
        issue(LCT_CMD_ACT, 3'h1);
        check(gap >= 2, 1);
        acts.push_back(last_take);
        issue(LCT_CMD_PRE, 3'h0);
        issue(LCT_CMD_ACT, 3'h0);
        check(gap >= 3, 1);
        check(last_take - acts[0] >= 8, 1);
        acts.push_back(last_take);
        for (int b = 2; b < 5; b++) begin
            issue(LCT_CMD_ACT, b[2:0]);
            acts.push_back(last_take);
        end
        check(acts[4] - acts[0] >= 8, 1);
        check(acts[5] - acts[1] >= 8, 1);
    endtask
    task automatic t_lat();
        issue(LCT_CMD_ACT, 3'h5);
        for (int g = 0; g < 7; g++) begin
            i_grade = g[2:0];
            issue(LCT_CMD_RD, 3'h5);
            watch(READ_LATENCY_TABLE[4*g +: 4], 1'b1);
            issue(LCT_CMD_WR, 3'h5);
            watch(WRITE_LATENCY_TABLE[4*g +: 4], 1'b0);
        end
        issue(LCT_CMD_WR, 3'h5);
        issue(LCT_CMD_RD, 3'h5);
        check(gap >= 2, 1);
        issue(LCT_CMD_PRE, 3'h5);
        check(gap >= 2, 1);
    endtask
    task automatic t_power();
        issue(LCT_CMD_SREN, 3'h0);
        @(negedge i_clock);
        check(o_cke, 0);
        issue(LCT_CMD_SREX, 3'h0);
        check(gap >= 3, 1);
        issue(LCT_CMD_MRR, 3'h0);
        check(gap >= 18, 1);
        check(o_cke, 1);
        issue(LCT_CMD_PDEN, 3'h0);
        issue(LCT_CMD_PDEX, 3'h0);
        issue(LCT_CMD_MRR, 3'h0);
        check(gap >= 2, 1);
        issue(LCT_CMD_DPEN, 3'h0);
        issue(LCT_CMD_DPEX, 3'h0);
        check(gap >= DSC, 1);
    endtask
    initial begin
        i_nrst = 1'b0;
        i_req_valid = 1'b0;
        i_req_cmd = LCT_CMD_NOP;
        i_req_bank = 3'h0;
        i_configured = 1'b0;
        i_grade = 3'h0;
        repeat (3) @(negedge i_clock);
        i_nrst = 1'b1;
        t_boot();
        t_mode();
        t_bank();
        t_lat();
        t_power();
        check(dev_viol, 0);
        test_done();
    end
endmodule
